// File: emb_bus_ctrl.sv
// External memory and I/O bus control sequencer
`timescale 1ns/10ps
// Overview of operation
// - Space selects idle high; one goes low only for an access to it.
// - A select is low exactly while the access address is valid.
// - Memory strobe idles high, low only for data or program accesses.
// - I/O strobe idles high, low only for I/O space accesses.
// - Direction line reads high, low only during an external write.
// - Ready low stretches the access; resampled each machine cycle until high.
// - Ready is honoured only with two or more wait states programmed.
// - Ready is not looked at before the software wait states end.
// - Hold request from another master makes the bus lines float once granted.
// - Hold grant is low only while the bus lines are released.
// - In hold, selects, strobes and direction line float.
// - Wait-complete low from first wait state until the last one starts.
// - Wait-complete looped to ready adds exactly one external wait state.
// - Fetch flag low while an instruction fetch address is out.
// - Output-disable low floats all control outputs and the clock output.
// - Clock output rises at each machine cycle boundary.
module emb_bus_ctrl
    import emb_pkg::*;
#(
    parameter int ADDR_W = ADDR_W_DEF,
    parameter int DATA_W = DATA_W_DEF,
    parameter int WS_W = WS_W_DEF
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic access_req,
    input wire logic [1:0] access_space,
    input wire logic access_write,
    input wire logic access_fetch,
    input wire logic [ADDR_W-1:0] access_addr,
    input wire logic [DATA_W-1:0] access_wdata,
    output logic access_done,
    output logic [DATA_W-1:0] access_rdata,
    input wire logic [WS_W-1:0] wait_states_data,
    input wire logic [WS_W-1:0] wait_states_prog,
    input wire logic [WS_W-1:0] wait_states_io,
    input wire logic ready_in,
    input wire logic hold_request_n,
    input wire logic output_disable_n,
    output logic [ADDR_W-1:0] ext_addr,
    output logic [DATA_W-1:0] ext_data_out,
    output logic ext_data_oe,
    input wire logic [DATA_W-1:0] ext_data_in,
    output logic data_space_select_n,
    output logic program_space_select_n,
    output logic io_space_select_n,
    output logic memory_access_strobe_n,
    output logic io_access_strobe_n,
    output logic read_write_dir,
    output logic bus_ctrl_oe,
    output logic bus_hold_grant_n,
    output logic wait_sequence_complete_n,
    output logic instruction_fetch_flag_n,
    output logic machine_cycle_clock_out,
    output logic status_pins_oe
);
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_ACCESS,
        ST_WAIT,
        ST_READY,
        ST_HOLD
    } emb_state_t;

    emb_state_t state_r, state_nxt;
    logic tick;
    logic ready_s;
    logic hold_n_s;
    logic off_n_s;
    logic [DATA_W-1:0] data_s;
    logic [WS_W-1:0] ws_pick;
    logic [WS_W-1:0] ws_r, ws_nxt;
    logic [WS_W-1:0] wcnt_r, wcnt_nxt;
    emb_space_t space_r, space_nxt;
    logic write_r, write_nxt;
    logic fetch_r, fetch_nxt;
    logic [ADDR_W-1:0] addr_r, addr_nxt;
    logic [DATA_W-1:0] wdata_r, wdata_nxt;
    logic [DATA_W-1:0] rdata_r, rdata_nxt;
    logic done_r, done_nxt, cap_r, cap_nxt;
    logic msc_r, msc_nxt;
    logic finish;
    logic active_nxt;
    logic ds_r, ps_r, is_r, ms_r, ios_r, rw_r, iaq_r, grant_r, doe_r, boe_r, poe_r;
    logic ds_nxt, ps_nxt, is_nxt, ms_nxt, ios_nxt, rw_nxt, iaq_nxt, grant_nxt;
    logic doe_nxt, boe_nxt, poe_nxt;

    // Machine cycle timing and clock output
    // cycle clock source
    emb_cycle_clk u_cycle_clk (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .cycle_tick(tick),
        .clk_out(machine_cycle_clock_out)
    );

    // Pin inputs cross into the ref_clk domain here
    emb_sync2 #(.WIDTH(1), .RST_VAL(RST_SYNC_HIGH)) u_sync_ready (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(ready_in),
        .sync_out(ready_s)
    );
    emb_sync2 #(.WIDTH(1), .RST_VAL(RST_SYNC_HIGH)) u_sync_hold (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(hold_request_n),
        .sync_out(hold_n_s)
    );
    emb_sync2 #(.WIDTH(1), .RST_VAL(RST_SYNC_HIGH)) u_sync_off (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(output_disable_n),
        .sync_out(off_n_s)
    );
    emb_sync2 #(.WIDTH(DATA_W), .RST_VAL(1'b0)) u_sync_data (
        .ref_clk(ref_clk),
        .reset_n(reset_n),
        .async_in(ext_data_in),
        .sync_out(data_s)
    );

    // Wait state count chosen by the requested space
    // per-space wait states
    always_comb begin
        case (access_space)
            EMB_SP_DATA: ws_pick = wait_states_data;
            EMB_SP_PROG: ws_pick = wait_states_prog;
            default: ws_pick = wait_states_io;
        endcase
    end

    // Access sequencer; moves only on machine cycle boundaries
    always_comb begin
        state_nxt = state_r;
        ws_nxt = ws_r;
        wcnt_nxt = wcnt_r;
        space_nxt = space_r;
        write_nxt = write_r;
        fetch_nxt = fetch_r;
        addr_nxt = addr_r;
        wdata_nxt = wdata_r;
        rdata_nxt = rdata_r;
        msc_nxt = msc_r;
        finish = 1'b0;
        if (tick) begin
            case (state_r)
                ST_IDLE: begin
                    if (!hold_n_s) begin
                        state_nxt = ST_HOLD;
                    end else if (access_req && !done_r) begin // Not while done still stands
                        state_nxt = ST_ACCESS;
                        ws_nxt = ws_pick;
                        space_nxt = (access_space == 2'h3) ? EMB_SP_IO : emb_space_t'(access_space);
                        write_nxt = access_write;
                        fetch_nxt = access_fetch;
                        addr_nxt = access_addr;
                        wdata_nxt = access_wdata;
                    end
                end
                ST_ACCESS: begin
                    if (ws_r == '0) begin
                        finish = 1'b1;
                    end else begin
                        state_nxt = ST_WAIT;
                        wcnt_nxt = ws_r;
                        msc_nxt = !(ws_r >= WS_W'(MIN_READY_WS));
                    end
                end
                ST_WAIT: begin
                    if (wcnt_r > WS_W'(1)) begin
                        wcnt_nxt = wcnt_r - 1'b1;
                        // released as last wait state starts
                        if (wcnt_r == WS_W'(2)) begin
                            msc_nxt = 1'b1;
                        end
                    // ready honoured only with enough wait states
                    // sampled only after the software waits
                    end else if (ws_r >= WS_W'(MIN_READY_WS) && !ready_s) begin
                        state_nxt = ST_READY;
                    end else begin
                        finish = 1'b1;
                    end
                end
                ST_READY: begin
                    // loopback lag yields one external wait
                    if (ready_s) begin
                        finish = 1'b1;
                    end
                end
                ST_HOLD: begin
                    // bus returns once the request is removed
                    if (hold_n_s) begin
                        state_nxt = ST_IDLE;
                    end
                end
                default: state_nxt = ST_IDLE;
            endcase
        end
        if (finish) begin
            state_nxt = ST_IDLE;
            msc_nxt = RST_MSC_N;
        end
        // Capture one edge late so the synced sample lies inside the select window
        if (cap_r && !write_r) begin
            rdata_nxt = data_s;
        end
        cap_nxt = finish;
        done_nxt = cap_r;
    end

    // Pin levels follow the next state so each pin is a flop output
    always_comb begin
        active_nxt = (state_nxt == ST_ACCESS) || (state_nxt == ST_WAIT)
            || (state_nxt == ST_READY);
        // one select, only for the space in use
        // select low for the whole address phase
        ds_nxt = !(active_nxt && space_nxt == EMB_SP_DATA);
        ps_nxt = !(active_nxt && space_nxt == EMB_SP_PROG);
        is_nxt = !(active_nxt && space_nxt == EMB_SP_IO);
        // memory strobe for data or program space
        ms_nxt = !(active_nxt && space_nxt != EMB_SP_IO);
        ios_nxt = !(active_nxt && space_nxt == EMB_SP_IO);
        // direction low only during a write
        rw_nxt = !(active_nxt && write_nxt);
        // fetch flag with an instruction address out
        iaq_nxt = !(active_nxt && fetch_nxt);
        grant_nxt = (state_nxt != ST_HOLD);
        // everything floats while outputs are disabled
        boe_nxt = off_n_s && (state_nxt != ST_HOLD);
        doe_nxt = boe_nxt && active_nxt && write_nxt;
        poe_nxt = off_n_s;
    end

    // Sequencer and pin registers
    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= ST_IDLE;
            ws_r <= '0;
            wcnt_r <= '0;
            space_r <= EMB_SP_DATA;
            write_r <= 1'b0;
            fetch_r <= 1'b0;
            addr_r <= '0;
            wdata_r <= '0;
            rdata_r <= '0;
            done_r <= 1'b0;
            cap_r <= 1'b0;
            msc_r <= RST_MSC_N;
            ds_r <= RST_SELECT_N;
            ps_r <= RST_SELECT_N;
            is_r <= RST_SELECT_N;
            ms_r <= RST_STROBE_N;
            ios_r <= RST_STROBE_N;
            rw_r <= RST_DIR_READ;
            iaq_r <= RST_FETCH_N;
            grant_r <= RST_GRANT_N;
            boe_r <= 1'b0;
            doe_r <= 1'b0;
            poe_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            ws_r <= ws_nxt;
            wcnt_r <= wcnt_nxt;
            space_r <= space_nxt;
            write_r <= write_nxt;
            fetch_r <= fetch_nxt;
            addr_r <= addr_nxt;
            wdata_r <= wdata_nxt;
            rdata_r <= rdata_nxt;
            done_r <= done_nxt;
            cap_r <= cap_nxt;
            msc_r <= msc_nxt;
            ds_r <= ds_nxt;
            ps_r <= ps_nxt;
            is_r <= is_nxt;
            ms_r <= ms_nxt;
            ios_r <= ios_nxt;
            rw_r <= rw_nxt;
            iaq_r <= iaq_nxt;
            grant_r <= grant_nxt;
            boe_r <= boe_nxt;
            doe_r <= doe_nxt;
            poe_r <= poe_nxt;
        end
    end

    assign access_done = done_r;
    assign access_rdata = rdata_r;
    assign ext_addr = addr_r;
    assign ext_data_out = wdata_r;
    assign ext_data_oe = doe_r;
    assign data_space_select_n = ds_r;
    assign program_space_select_n = ps_r;
    assign io_space_select_n = is_r;
    assign memory_access_strobe_n = ms_r;
    assign io_access_strobe_n = ios_r;
    assign read_write_dir = rw_r;
    assign bus_ctrl_oe = boe_r;
    assign bus_hold_grant_n = grant_r;
    assign wait_sequence_complete_n = msc_r;
    assign instruction_fetch_flag_n = iaq_r;
    assign status_pins_oe = poe_r;

    // Checks on the sequencer and pins
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!reset_n);

    sequence seq_long_wait_start;
        tick && state_r == ST_ACCESS && ws_r >= WS_W'(MIN_READY_WS);
    endsequence
    sequence seq_soft_waits_end;
        tick && state_r == ST_WAIT && wcnt_r == WS_W'(1);
    endsequence

    chk_select_one_space: assert property (
        $onehot0(~{ds_r, ps_r, is_r}))
        else $error("more than one space select low");
    chk_select_addr_stable: assert property (
        (!ds_r || !ps_r || !is_r) && $past(!ds_r || !ps_r || !is_r) |-> $stable(ext_addr))
        else $error("address moved while a select was low");
    chk_mem_strobe_space: assert property (
        !ms_r |-> (!ds_r || !ps_r) && is_r && ios_r)
        else $error("memory strobe low outside data or program access");
    chk_io_strobe_space: assert property (
        !ios_r |-> !is_r && ms_r)
        else $error("I/O strobe low outside an I/O access");
    chk_dir_write_only: assert property (
        !rw_r |-> write_r && (!ds_r || !ps_r || !is_r))
        else $error("direction low without a write access");
    chk_ready_stretch: assert property (
        tick && state_r == ST_READY && !ready_s |=> state_r == ST_READY && !done_r)
        else $error("access ended while ready was low");
    chk_ready_ignored: assert property (
        seq_soft_waits_end and (ws_r < WS_W'(MIN_READY_WS)) |=> state_r == ST_IDLE ##1 done_r)
        else $error("short access did not finish on time");
    chk_ready_after_waits: assert property (
        tick && state_r == ST_WAIT && wcnt_r > WS_W'(1) |=> state_r == ST_WAIT)
        else $error("wait states cut short");
    chk_msc_start: assert property (
        seq_long_wait_start |=> !msc_r ##0 (msc_r == 1'b0) [*2])
        else $error("wait-complete not driven at first wait state");
    chk_msc_release: assert property (
        seq_soft_waits_end and (ws_r >= WS_W'(MIN_READY_WS)) |-> msc_r)
        else $error("wait-complete still low in last wait state");
    chk_hold_float: assert property (
        !grant_r |-> !boe_r && !doe_r)
        else $error("bus driven while hold granted");
    chk_grant_cause: assert property (
        $fell(grant_r) |-> $past(state_r) == ST_IDLE && !$past(hold_n_s))
        else $error("hold granted during an access or without request");
    chk_off_float: assert property (
        !off_n_s |=> !poe_r && !boe_r && !doe_r)
        else $error("outputs driven while disabled");
    chk_clock_boundary: assert property (
        tick |=> machine_cycle_clock_out ##1 !machine_cycle_clock_out)
        else $error("clock output not aligned to machine cycle");
    chk_fetch_flag: assert property (
        !iaq_r |-> fetch_r && (!ds_r || !ps_r || !is_r))
        else $error("fetch flag low without a fetch address");
endmodule

// File: emb_cycle_clk.sv
// Machine cycle clock generator and cycle boundary tick
`timescale 1ns/10ps
module emb_cycle_clk
    import emb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic reset_n,
    output logic cycle_tick,
    output logic clk_out
);
    logic [MC_CNT_W-1:0] phase_r;
    logic [MC_CNT_W-1:0] phase_nxt;
    logic clk_r;
    logic clk_nxt;

    // Phase wraps each machine cycle; clock rises as a cycle starts
    always_comb begin
        if (phase_r == MC_CNT_W'(MC_DIV - 1)) begin
            phase_nxt = '0;
        end else begin
            phase_nxt = phase_r + 1'b1;
        end
        clk_nxt = (phase_nxt < MC_CNT_W'(MC_DIV / 2));
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            phase_r <= '0;
            clk_r <= 1'b0;
        end else begin
            phase_r <= phase_nxt;
            clk_r <= clk_nxt;
        end
    end

    assign cycle_tick = (phase_r == MC_CNT_W'(MC_DIV - 1));
    assign clk_out = clk_r;
endmodule

// File: emb_ext_device.sv
// Behavioural external memory and I/O device facing the control bus
`timescale 1ns/10ps
module emb_ext_device
    import emb_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sel_low,
    input wire logic [15:0] ext_addr,
    input wire logic [15:0] ext_data_out,
    input wire logic ext_data_oe,
    input wire logic read_write_dir,
    input wire logic wait_sequence_complete_n,
    input wire logic [1:0] ready_mode,
    input wire logic [7:0] stall_len,
    output logic [15:0] ext_data_in,
    output logic ready_in,
    output logic [15:0] last_wdata
);
    logic [7:0] busy_cnt_r;
    logic [15:0] last_rd_r;

    // Cycles spent selected, last word read out and last word written in
    always_ff @(posedge ref_clk) begin
        busy_cnt_r <= sel_low ? busy_cnt_r + 8'h01 : 8'h00;
        if (sel_low) begin
            last_rd_r <= ext_addr ^ 16'hA5C3;
        end
        if (sel_low && !read_write_dir && ext_data_oe) begin
            last_wdata <= ext_data_out;
        end
    end

    // Released lines show the inverse of the last word, not a stale copy
    assign ext_data_in = sel_low ? (ext_addr ^ 16'hA5C3) : ~last_rd_r;

    always_comb begin
        case (ready_mode)
            2'h1: ready_in = wait_sequence_complete_n; // Loopback of wait-complete
            2'h2: ready_in = (busy_cnt_r >= stall_len); // Busy for a set time
            default: ready_in = 1'h1;
        endcase
    end
endmodule

// File: emb_pkg.sv
// Shared constants and types for the external memory bus controller
package emb_pkg;
    // Reference clock and machine cycle timing
    localparam int REF_CLK_PERIOD_NS = 50;
    localparam int MC_DIV = 2;
    localparam int MC_CNT_W = 1;
    // Default widths
    localparam int ADDR_W_DEF = 16;
    localparam int DATA_W_DEF = 16;
    localparam int WS_W_DEF = 3;
    // Least programmed wait states before the ready input is honoured
    localparam int MIN_READY_WS = 2;
    // Values after reset
    localparam logic RST_SELECT_N = 1'b1;
    localparam logic RST_STROBE_N = 1'b1;
    localparam logic RST_DIR_READ = 1'b1;
    localparam logic RST_GRANT_N = 1'b1;
    localparam logic RST_MSC_N = 1'b1;
    localparam logic RST_FETCH_N = 1'b1;
    localparam logic RST_SYNC_HIGH = 1'b1;
    // Address spaces
    typedef enum logic [1:0] {
        EMB_SP_DATA = 2'h0,
        EMB_SP_PROG = 2'h1,
        EMB_SP_IO = 2'h2
    } emb_space_t;
endpackage

// File: emb_sync2.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/10ps
module emb_sync2
    import emb_pkg::*;
#(
    parameter int WIDTH = 1,
    parameter logic RST_VAL = 1'b0
) (
    input wire logic ref_clk,
    input wire logic reset_n,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    logic [WIDTH-1:0] meta_r;
    logic [WIDTH-1:0] meta_nxt;
    logic [WIDTH-1:0] sync_r;
    logic [WIDTH-1:0] sync_nxt;

    // First stage feeds only the second stage
    always_comb begin
        meta_nxt = async_in;
        sync_nxt = meta_r;
    end

    always_ff @(posedge ref_clk or negedge reset_n) begin
        if (!reset_n) begin
            meta_r <= {WIDTH{RST_VAL}};
            sync_r <= {WIDTH{RST_VAL}};
        end else begin
            meta_r <= meta_nxt;
            sync_r <= sync_nxt;
        end
    end

    assign sync_out = sync_r;
endmodule

// File: external_memory_bus_control_tb_top.sv
// Self-checking bench for the external bus control sequencer
`timescale 1ns/10ps
module external_memory_bus_control_tb_top
    import emb_pkg::*;
;
    logic ref_clk, reset_n, access_req, access_write, access_fetch, access_done;
    logic ready_in, hold_request_n, output_disable_n, ext_data_oe, bus_ctrl_oe;
    logic data_space_select_n, program_space_select_n, io_space_select_n;
    logic memory_access_strobe_n, io_access_strobe_n, read_write_dir, status_pins_oe;
    logic bus_hold_grant_n, wait_sequence_complete_n, instruction_fetch_flag_n;
    logic machine_cycle_clock_out, mon_on, exp_wr, exp_fetch;
    logic [1:0] access_space, ready_mode, exp_sp;
    logic [2:0] wait_states_data, wait_states_prog, wait_states_io, exp_sel;
    logic [7:0] stall_len;
    logic [15:0] access_addr, access_wdata, access_rdata, ext_addr, ext_data_out;
    logic [15:0] ext_data_in, last_wdata, exp_addr, exp_wdata;
    int fails, comparisons, sel_cnt, msc_cnt, cur_ws, cur_md, cur_st;
    int ws_tab[4] = '{0, 1, 2, 7};

    emb_bus_ctrl u_dut (
        .ref_clk, .reset_n, .access_req, .access_space, .access_write, .access_fetch,
        .access_addr, .access_wdata, .access_done, .access_rdata, .wait_states_data,
        .wait_states_prog, .wait_states_io, .ready_in, .hold_request_n, .output_disable_n,
        .ext_addr, .ext_data_out, .ext_data_oe, .ext_data_in, .data_space_select_n,
        .program_space_select_n, .io_space_select_n, .memory_access_strobe_n,
        .io_access_strobe_n, .read_write_dir, .bus_ctrl_oe, .bus_hold_grant_n,
        .wait_sequence_complete_n, .instruction_fetch_flag_n, .machine_cycle_clock_out,
        .status_pins_oe
    );

    // Far-side device sees a select only while the pins are really driven
    emb_ext_device u_dev (
        .ref_clk,
        .sel_low(~(data_space_select_n & program_space_select_n & io_space_select_n)
            & bus_ctrl_oe),
        .ext_addr, .ext_data_out, .ext_data_oe, .read_write_dir,
        .wait_sequence_complete_n, .ready_mode, .stall_len, .ext_data_in,
        .ready_in, .last_wdata
    );

    // Free-running reference clock
    initial begin
        ref_clk = 1'h0;
        forever #25 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            fails++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic results();
        $display("Comparisons %0d, fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Select-low length in reference cycles; ready only counts from two waits up
    function automatic int exp_len(input int ws, input int md, input int st);
        if (ws < MIN_READY_WS || md == 0) begin
            return 2 * (1 + ws);
        end
        if (md == 1) begin
            return 2 * (2 + ws);
        end
        return (st > 2 * (1 + ws)) ? st : 2 * (1 + ws);
    endfunction

    // Raise a request; unused spaces get random wait counts to catch a wrong pick
    task automatic start_acc(input int sp, input int wr, input int md, input int ws);
        @(posedge ref_clk);
        exp_sp = sp[1:0];
        exp_wr = wr[0];
        exp_fetch = (sp == 1) && (wr == 0);
        exp_sel = 3'h7;
        exp_sel[2 - sp] = 1'h0;
        exp_addr = 16'($urandom);
        exp_wdata = 16'($urandom);
        cur_ws = ws;
        cur_md = md;
        cur_st = 6 + $urandom_range(14);
        sel_cnt = 0;
        msc_cnt = 0;
        access_space <= sp[1:0];
        access_write <= wr[0];
        access_fetch <= exp_fetch;
        access_addr <= exp_addr;
        access_wdata <= exp_wdata;
        wait_states_data <= (sp == 0) ? 3'(ws) : 3'($urandom);
        wait_states_prog <= (sp == 1) ? 3'(ws) : 3'($urandom);
        wait_states_io <= (sp == 2) ? 3'(ws) : 3'($urandom);
        ready_mode <= 2'(md);
        stall_len <= 8'(cur_st);
        access_req <= 1'h1;
    endtask

    // Bounded wait for the done pulse, then judge length, wait-complete and data
    task automatic finish_acc();
        int n;
        int lo;
        n = 0;
        lo = exp_len(cur_ws, cur_md, cur_st);
        do begin
            @(posedge ref_clk);
            #1;
            n++;
        end while (access_done !== 1'h1 && n < 400);
        if (access_done !== 1'h1) begin
            fails++;
            results();
        end
        check(sel_cnt, (cur_md == 2 && sel_cnt >= lo && sel_cnt <= lo + 8) ? sel_cnt : lo);
        check(msc_cnt, (cur_ws >= MIN_READY_WS) ? 2 * (cur_ws - 1) : 0);
        if (exp_wr) begin
            check(last_wdata, exp_wdata);
        end else begin
            check(access_rdata, exp_addr ^ 16'hA5C3);
        end
        @(posedge ref_clk);
        access_req <= 1'h0;
    endtask

    // Pin relations, sampled mid-cycle away from the launching edge
    always @(negedge ref_clk) begin
        logic [2:0] sel;
        sel = {data_space_select_n, program_space_select_n, io_space_select_n};
        if (mon_on && sel !== 3'h7) begin
            sel_cnt++;
            check(sel, exp_sel);
            check(ext_addr, exp_addr);
            check(bus_ctrl_oe, 1'h1);
            check(memory_access_strobe_n, exp_sp == 2'h2);
            check(io_access_strobe_n, exp_sp != 2'h2);
            check(read_write_dir, !exp_wr);
            check(instruction_fetch_flag_n, !exp_fetch);
            check(bus_hold_grant_n, 1'h1);
        end else if (mon_on) begin
            check({memory_access_strobe_n, io_access_strobe_n, read_write_dir}, 3'h7);
        end
        if (mon_on && wait_sequence_complete_n === 1'h0) begin
            msc_cnt++;
        end
        if (mon_on && bus_hold_grant_n === 1'h0) begin
            check({bus_ctrl_oe, sel}, 4'h7);
        end
    end

    // Main sequence
    initial begin
        int i;
        logic prev;
        void'($urandom(13378));
        reset_n = 1'h0;
        mon_on = 1'h0;
        access_req = 1'h0;
        access_space = 2'h0;
        access_write = 1'h0;
        access_fetch = 1'h0;
        access_addr = 16'h0000;
        access_wdata = 16'h0000;
        wait_states_data = 3'h0;
        wait_states_prog = 3'h0;
        wait_states_io = 3'h0;
        hold_request_n = 1'h1;
        output_disable_n = 1'h1;
        ready_mode = 2'h0;
        stall_len = 8'h00;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'h1;
        repeat (4) @(posedge ref_clk);
        mon_on <= 1'h1;
        // Corner table: every space, both directions, all ready modes, edge waits
        for (i = 0; i < 12; i++) begin
            start_acc(i % 3, i % 2, (i / 4) % 3, ws_tab[i % 4]);
            finish_acc();
        end
        // Random accesses
        for (i = 0; i < 24; i++) begin
            start_acc($urandom_range(2), $urandom_range(1), $urandom_range(2),
                $urandom_range(7));
            finish_acc();
        end
        // Hold in mid-access: the access ends first, then the bus floats
        start_acc(2, 1, 0, 3);
        repeat (3) @(posedge ref_clk);
        hold_request_n <= 1'h0;
        finish_acc();
        i = 0;
        do begin
            @(posedge ref_clk);
            #1;
            i++;
        end while (bus_hold_grant_n !== 1'h0 && i < 12);
        check(bus_hold_grant_n, 1'h0);
        check(bus_ctrl_oe, 1'h0);
        // A request during hold waits until the hold is dropped
        start_acc(0, 0, 0, 0);
        repeat (12) @(posedge ref_clk);
        check(sel_cnt, 0);
        hold_request_n <= 1'h1;
        finish_acc();
        check(bus_hold_grant_n, 1'h1);
        // Output disable floats both groups, then they come back
        output_disable_n <= 1'h0;
        repeat (6) @(posedge ref_clk);
        check({bus_ctrl_oe, status_pins_oe}, 2'h0);
        output_disable_n <= 1'h1;
        repeat (6) @(posedge ref_clk);
        check({bus_ctrl_oe, status_pins_oe}, 2'h3);
        // Clock output flips every reference cycle: two per machine cycle
        #1;
        for (i = 0; i < 16; i++) begin
            prev = machine_cycle_clock_out;
            @(posedge ref_clk);
            #1;
            check(machine_cycle_clock_out, !prev);
        end
        results();
    end
endmodule
